/* design/mac_ctl_pkg.sv */
// constants for the mac status, transmit control and receive control block
package mac_ctl_pkg;
  // register offsets (word indices; the bus byte address is four times the offset)
  localparam logic [7:0] IDX_NET_STATUS = 8'h01;
  localparam logic [7:0] IDX_TX_CONTROL = 8'h02;
  localparam logic [7:0] IDX_RX_CONTROL = 8'h05;
  localparam logic [7:0] IDX_RX_FRAME_STATUS = 8'h06;
  localparam logic [7:0] IDX_NET_CONTROL = 8'h00;
  localparam logic [7:0] IDX_FORCE_MODE = 8'h2E;
  localparam int ADDR_W = 10;
  // network status fields
  localparam int NS_SPEED = 7;
  localparam int NS_LINK = 6;
  localparam int NS_WAKE = 5;
  localparam int NS_LOWSPACE = 1;
  localparam int NS_RX_PACKET_WAITING = 0;
  // network control fields
  localparam int NC_EXTPHY = 7;
  localparam int NC_WAKEON = 6;
  // force mode fields
  localparam int FM_FORCE = 5;
  localparam int FM_SPEED = 2;
  localparam int FM_LINK = 0;
  // transmit control fields
  localparam int TC_GUARD_OFF = 6;
  localparam int TC_RETRY = 5;
  localparam int TC_PAD_OFF = 2;
  localparam int TC_FCS_OFF = 1;
  localparam logic [7:0] TC_WMASK = 8'h7F;
  // receive control fields
  localparam int RC_HASH_FILTER_EVERY_ADDRESS = 7;
  localparam int RC_GUARD_OFF = 6;
  localparam int RC_DROP_LONG = 5;
  localparam int RC_DROP_FCS = 4;
  localparam int RC_ALLMC = 3;
  localparam int RC_RUNT = 2;
  localparam int RC_PROMISC = 1;
  localparam int RC_RECEIVE_STORE_ON = 0;
  // receive frame status fields
  localparam int RS_RUNT = 7;
  localparam int RS_MCAST = 6;
  localparam int RS_LATECOL = 5;
  localparam int RS_TIMEOUT = 4;
  localparam int RS_PHYERR = 3;
  localparam int RS_ALIGN = 2;
  localparam int RS_FCS = 1;
  localparam int RS_OVERRUN = 0;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // frame length limits in bytes, and the transmit collision limit
  localparam int LEN_W = 12;
  localparam logic [LEN_W-1:0] LEN_GUARD = 12'h800;
  localparam logic [LEN_W-1:0] LEN_MIN = 12'h040;
  localparam logic [LEN_W-1:0] LEN_LONG = 12'h5F2;
  localparam logic [4:0] COLL_MAX = 5'h0F;
  // receive fifo hysteresis thresholds in bytes
  localparam int SPACE_W = 16;
  localparam logic [SPACE_W-1:0] SPACE_LOW = 16'h0220;
  localparam logic [SPACE_W-1:0] SPACE_HIGH = 16'h0800;
endpackage : mac_ctl_pkg

/* design/mac_status_tx_rx_control.sv */
// status, transmit control and receive filter logic of a fast ethernet mac
// Summary of operation
// - speed flag reads 0 for 100 Mbit/s, 1 for 10; meaningless with link down
// - speed and link flags read-only with inside phy, writable with outside phy
// - link flag 0 on failure, 1 when good; force-mode register may override it
// - wakeup event flag sets on event, clears on write 1 or wakeup disable
// - low space flag sets below 544 free bytes, clears above 2K bytes
// - packet waiting flag high while at least one whole packet is stored
// - unless guard off, transmitted packets stop at 2048 bytes
// - retry bit 0 aborts after more than 15 collisions; 1 keeps retrying
// - padding on extends transmit frames to at least 64 bytes
// - fcs append on makes the transmitter append the frame check sequence
// - receive guard on truncates frames after 2048 bytes
// - drop oversize drops received frames longer than 1522 bytes
// - drop bad fcs drops received frames failing the frame check
// - pass all multicast stores every multicast frame despite hash filter
// - pass runt stores frames shorter than 64 bytes
// - promiscuous mode accepts any destination address
// - frames are stored only while receive store is on
// - frame status flags runts and multicast destinations
// - frame status flags late collision and phy error separately
// - frame status flags more than 2048 bytes received
// - frame status flags misaligned end and fcs error separately
// - frame status flags fifo overrun during reception
// - outside phy select bit chooses phy, valid only with test strap low
// - clearing wakeup enable clears all wakeup event status
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module mac_status_tx_rx_control
  import mac_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins and internal phy status
  input wire logic test_strap,
  input wire logic phy_link_ok,
  input wire logic phy_speed_10,
  input wire logic wakeup_event,
  // receive fifo state
  input wire logic [SPACE_W-1:0] rx_free_space,
  input wire logic [7:0] rx_packet_count,
  // receive frame side
  input wire logic rx_frame_end,
  input wire logic [LEN_W-1:0] rx_frame_len,
  input wire logic rx_dest_multicast,
  input wire logic rx_dest_match,
  input wire logic rx_hash_match,
  input wire logic rx_late_collision,
  input wire logic rx_phy_error,
  input wire logic rx_odd_bits,
  input wire logic rx_fcs_bad,
  input wire logic rx_fifo_overran,
  input wire logic rx_byte_valid,
  input wire logic [LEN_W-1:0] rx_byte_count,
  // transmit side
  input wire logic tx_byte_valid,
  input wire logic [LEN_W-1:0] tx_byte_count,
  input wire logic tx_collision,
  input wire logic tx_frame_start,
  // outputs to datapath
  output logic rx_store_frame,
  output logic rx_store_byte,
  output logic tx_stop_frame,
  output logic tx_abort_frame,
  output logic tx_pad_enable,
  output logic tx_fcs_enable,
  output logic outside_phy_select
);

  // synchronised pin level, three stages, a change counts once stages 2 and 3 agree
  function automatic logic sync_pick(input logic [2:0] s, input logic cur);
    sync_pick = (s[1] == s[2]) ? s[2] : cur;
  endfunction : sync_pick

  function automatic logic byte_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    byte_hit = (a == {idx[ADDR_W-3:0], 2'b00});
  endfunction : byte_hit

  logic [2:0] strap_s_r, strap_s_nxt;
  logic [2:0] link_s_r, link_s_nxt;
  logic [2:0] spd_s_r, spd_s_nxt;
  logic [2:0] wake_s_r, wake_s_nxt;
  logic strap_r, strap_nxt;
  logic link_in_r, link_in_nxt;
  logic spd_in_r, spd_in_nxt;
  logic wake_lvl_r, wake_lvl_nxt;

  // pin synchronisers; the first stage feeds only the second
  always_comb begin
    strap_s_nxt = {strap_s_r[1:0], test_strap};
    link_s_nxt = {link_s_r[1:0], phy_link_ok};
    spd_s_nxt = {spd_s_r[1:0], phy_speed_10};
    wake_s_nxt = {wake_s_r[1:0], wakeup_event};
    strap_nxt = sync_pick(strap_s_r, strap_r);
    link_in_nxt = sync_pick(link_s_r, link_in_r);
    spd_in_nxt = sync_pick(spd_s_r, spd_in_r);
    wake_lvl_nxt = sync_pick(wake_s_r, wake_lvl_r);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_s_r <= 3'h0;
      link_s_r <= 3'h0;
      spd_s_r <= 3'h0;
      wake_s_r <= 3'h0;
      strap_r <= 1'b0;
      link_in_r <= 1'b0;
      spd_in_r <= 1'b0;
      wake_lvl_r <= 1'b0;
    end else begin
      strap_s_r <= strap_s_nxt;
      link_s_r <= link_s_nxt;
      spd_s_r <= spd_s_nxt;
      wake_s_r <= wake_s_nxt;
      strap_r <= strap_nxt;
      link_in_r <= link_in_nxt;
      spd_in_r <= spd_in_nxt;
      wake_lvl_r <= wake_lvl_nxt;
    end
  end

  // register file state
  logic [7:0] net_control_r, net_control_nxt;
  logic [7:0] force_mode_r, force_mode_nxt;
  logic [7:0] transmit_control_r, transmit_control_nxt;
  logic [7:0] receive_control_r, receive_control_nxt;
  logic [7:0] receive_frame_status_r, receive_frame_status_nxt;
  logic sw_link_r, sw_link_nxt;
  logic sw_speed_r, sw_speed_nxt;
  logic wakeup_event_flag_r, wakeup_event_flag_nxt;
  logic rx_fifo_low_space_flag_r, rx_fifo_low_space_flag_nxt;
  logic rx_packet_waiting_r, rx_packet_waiting_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;

  logic wr_go, rd_go, ext_mode, link_up_flag, speed_flag;
  logic [7:0] wbyte, status_view;

  // a request is answered one cycle after it appears: waitrequest drops for one cycle
  assign wr_go = avs_write && !wait_r && avs_byteenable[0];
  assign rd_go = avs_read && wait_r;
  assign wbyte = avs_writedata[7:0];
  assign ext_mode = net_control_r[NC_EXTPHY] && !strap_r;

  // forced values win, then software value in outside phy mode, else internal phy
  always_comb begin
    if (force_mode_r[FM_FORCE]) begin
      link_up_flag = force_mode_r[FM_LINK];
      speed_flag = force_mode_r[FM_SPEED];
    end else if (ext_mode) begin
      link_up_flag = sw_link_r;
      speed_flag = sw_speed_r;
    end else begin
      link_up_flag = link_in_r;
      speed_flag = spd_in_r;
    end
    status_view = 8'h00;
    status_view[NS_SPEED] = speed_flag;
    status_view[NS_LINK] = link_up_flag;
    status_view[NS_WAKE] = wakeup_event_flag_r;
    status_view[NS_LOWSPACE] = rx_fifo_low_space_flag_r;
    status_view[NS_RX_PACKET_WAITING] = rx_packet_waiting_r;
  end

  // register writes, status flag updates and the read path
  always_comb begin
    net_control_nxt = net_control_r;
    force_mode_nxt = force_mode_r;
    transmit_control_nxt = transmit_control_r;
    receive_control_nxt = receive_control_r;
    sw_link_nxt = sw_link_r;
    sw_speed_nxt = sw_speed_r;
    wakeup_event_flag_nxt = wakeup_event_flag_r;
    rdata_nxt = rdata_r;
    wait_nxt = 1'b1;
    if ((avs_read || avs_write) && wait_r) begin
      wait_nxt = 1'b0;
    end
    if (wr_go) begin
      if (byte_hit(avs_address, IDX_NET_CONTROL)) begin
        net_control_nxt = wbyte;
      end
      if (byte_hit(avs_address, IDX_FORCE_MODE)) begin
        force_mode_nxt = wbyte;
      end
      if (byte_hit(avs_address, IDX_TX_CONTROL)) begin
        transmit_control_nxt = wbyte & TC_WMASK;
      end
      if (byte_hit(avs_address, IDX_RX_CONTROL)) begin
        receive_control_nxt = wbyte;
      end
      if (byte_hit(avs_address, IDX_NET_STATUS)) begin
        if (ext_mode) begin
          sw_link_nxt = wbyte[NS_LINK];
          sw_speed_nxt = wbyte[NS_SPEED];
        end
        if (wbyte[NS_WAKE]) begin
          wakeup_event_flag_nxt = 1'b0;
        end
      end
    end
    // disabling wakeup clears the flag; a fresh event still wins over a write of 1
    if (!net_control_nxt[NC_WAKEON]) begin
      wakeup_event_flag_nxt = 1'b0;
    end else if (wake_lvl_r) begin
      wakeup_event_flag_nxt = 1'b1;
    end
    if (rd_go) begin
      rdata_nxt = 32'h0000_0000;
      if (byte_hit(avs_address, IDX_NET_STATUS)) begin
        rdata_nxt[7:0] = status_view;
      end else if (byte_hit(avs_address, IDX_TX_CONTROL)) begin
        rdata_nxt[7:0] = transmit_control_r;
      end else if (byte_hit(avs_address, IDX_RX_CONTROL)) begin
        rdata_nxt[7:0] = receive_control_r;
      end else if (byte_hit(avs_address, IDX_RX_FRAME_STATUS)) begin
        rdata_nxt[7:0] = receive_frame_status_r;
      end else if (byte_hit(avs_address, IDX_NET_CONTROL)) begin
        rdata_nxt[7:0] = net_control_r;
      end else if (byte_hit(avs_address, IDX_FORCE_MODE)) begin
        rdata_nxt[7:0] = force_mode_r;
      end
    end
  end

  // fifo space hysteresis and packet waiting follow the fifo state directly
  always_comb begin
    rx_fifo_low_space_flag_nxt = rx_fifo_low_space_flag_r;
    if (rx_free_space < SPACE_LOW) begin
      rx_fifo_low_space_flag_nxt = 1'b1;
    end else if (rx_free_space > SPACE_HIGH) begin
      rx_fifo_low_space_flag_nxt = 1'b0;
    end
    rx_packet_waiting_nxt = (rx_packet_count != 8'h00);
  end

  // receive filter decisions and frame status capture
  logic rx_pass_addr, rx_pass_len, rx_pass_fcs, rx_accept;
  logic rx_store_frame_nxt, rx_store_byte_nxt;
  logic rx_store_frame_r, rx_store_byte_r;

  always_comb begin
    rx_pass_addr = receive_control_r[RC_PROMISC]
                   || rx_dest_match || rx_hash_match
                   || receive_control_r[RC_HASH_FILTER_EVERY_ADDRESS]
                   || (rx_dest_multicast && receive_control_r[RC_ALLMC]);
    rx_pass_len = !((rx_frame_len < LEN_MIN) && !receive_control_r[RC_RUNT])
                  && !((rx_frame_len > LEN_LONG) && receive_control_r[RC_DROP_LONG]);
    rx_pass_fcs = !(rx_fcs_bad && receive_control_r[RC_DROP_FCS]);
    rx_accept = rx_pass_addr && rx_pass_len && rx_pass_fcs;
    rx_store_frame_nxt = rx_frame_end && rx_accept && receive_control_r[RC_RECEIVE_STORE_ON];
    // bytes beyond the guard are not written unless the guard is off
    rx_store_byte_nxt = rx_byte_valid && receive_control_r[RC_RECEIVE_STORE_ON]
                        && (receive_control_r[RC_GUARD_OFF] || rx_byte_count < LEN_GUARD);
    receive_frame_status_nxt = receive_frame_status_r;
    if (rx_frame_end) begin
      receive_frame_status_nxt[RS_RUNT] = rx_frame_len < LEN_MIN;
      receive_frame_status_nxt[RS_MCAST] = rx_dest_multicast;
      receive_frame_status_nxt[RS_LATECOL] = rx_late_collision;
      receive_frame_status_nxt[RS_PHYERR] = rx_phy_error;
      receive_frame_status_nxt[RS_TIMEOUT] = rx_frame_len > LEN_GUARD;
      receive_frame_status_nxt[RS_ALIGN] = rx_odd_bits;
      receive_frame_status_nxt[RS_FCS] = rx_fcs_bad;
      receive_frame_status_nxt[RS_OVERRUN] = rx_fifo_overran;
    end
  end

  // transmit control: jabber guard and collision counting per frame
  logic [4:0] coll_cnt_r, coll_cnt_nxt;
  logic tx_stop_nxt, tx_abort_nxt, tx_stop_r, tx_abort_r;

  always_comb begin
    coll_cnt_nxt = coll_cnt_r;
    if (tx_frame_start) begin
      coll_cnt_nxt = 5'h00;
    end else if (tx_collision && coll_cnt_r != 5'h1F) begin
      coll_cnt_nxt = coll_cnt_r + 5'h01;
    end
    // retry mode keeps going forever; the count simply saturates
    tx_abort_nxt = !transmit_control_r[TC_RETRY] && (coll_cnt_nxt > COLL_MAX);
    tx_stop_nxt = tx_byte_valid && !transmit_control_r[TC_GUARD_OFF]
                  && (tx_byte_count >= LEN_GUARD);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      net_control_r <= REG_RESET;
      force_mode_r <= REG_RESET;
      transmit_control_r <= REG_RESET;
      receive_control_r <= REG_RESET;
      receive_frame_status_r <= REG_RESET;
      sw_link_r <= 1'b0;
      sw_speed_r <= 1'b0;
      wakeup_event_flag_r <= 1'b0;
      rx_fifo_low_space_flag_r <= 1'b0;
      rx_packet_waiting_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
      rx_store_frame_r <= 1'b0;
      rx_store_byte_r <= 1'b0;
      coll_cnt_r <= 5'h00;
      tx_stop_r <= 1'b0;
      tx_abort_r <= 1'b0;
    end else begin
      net_control_r <= net_control_nxt;
      force_mode_r <= force_mode_nxt;
      transmit_control_r <= transmit_control_nxt;
      receive_control_r <= receive_control_nxt;
      receive_frame_status_r <= receive_frame_status_nxt;
      sw_link_r <= sw_link_nxt;
      sw_speed_r <= sw_speed_nxt;
      wakeup_event_flag_r <= wakeup_event_flag_nxt;
      rx_fifo_low_space_flag_r <= rx_fifo_low_space_flag_nxt;
      rx_packet_waiting_r <= rx_packet_waiting_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      rx_store_frame_r <= rx_store_frame_nxt;
      rx_store_byte_r <= rx_store_byte_nxt;
      coll_cnt_r <= coll_cnt_nxt;
      tx_stop_r <= tx_stop_nxt;
      tx_abort_r <= tx_abort_nxt;
    end
  end

  // outputs straight from flip-flops
  logic ext_mode_out_r, pad_on_r, fcs_on_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign rx_store_frame = rx_store_frame_r;
  assign rx_store_byte = rx_store_byte_r;
  assign tx_stop_frame = tx_stop_r;
  assign tx_abort_frame = tx_abort_r;
  assign tx_pad_enable = pad_on_r;
  assign tx_fcs_enable = fcs_on_r;
  assign outside_phy_select = ext_mode_out_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_mode_out_r <= 1'b0;
      pad_on_r <= 1'b1;
      fcs_on_r <= 1'b1;
    end else begin
      ext_mode_out_r <= ext_mode;
      pad_on_r <= !transmit_control_nxt[TC_PAD_OFF];
      fcs_on_r <= !transmit_control_nxt[TC_FCS_OFF];
    end
  end

endmodule : mac_status_tx_rx_control

/* sim/mac_ctl_sva.sv */
// assertion checker for the mac status and control block
`timescale 1ns/1ps
module mac_ctl_sva
  import mac_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic rx_frame_end,
  input wire logic [LEN_W-1:0] rx_frame_len,
  input wire logic rx_fcs_bad,
  input wire logic rx_byte_valid,
  input wire logic [LEN_W-1:0] rx_byte_count,
  input wire logic tx_byte_valid,
  input wire logic [LEN_W-1:0] tx_byte_count,
  input wire logic tx_collision,
  input wire logic tx_frame_start,
  input wire logic rx_store_frame,
  input wire logic rx_store_byte,
  input wire logic tx_stop_frame,
  input wire logic tx_abort_frame,
  input wire logic tx_pad_enable,
  input wire logic tx_fcs_enable
);
  logic [7:0] tc_r, tc_nxt, rc_r, rc_nxt;
  logic [4:0] col_r, col_nxt;
  logic hit;
  // shadow control bytes taken at the answering edge; count saturates so it cannot wrap
  always_comb begin
    hit = avs_write && !avs_waitrequest && avs_byteenable[0];
    tc_nxt = tc_r;
    rc_nxt = rc_r;
    col_nxt = col_r;
    if (hit && avs_address == {IDX_TX_CONTROL, 2'b00}) tc_nxt = avs_writedata[7:0] & TC_WMASK;
    if (hit && avs_address == {IDX_RX_CONTROL, 2'b00}) rc_nxt = avs_writedata[7:0];
    if (tx_frame_start) col_nxt = 5'h00;
    else if (tx_collision && col_r != 5'h1F) col_nxt = col_r + 5'h01;
  end
  // shadow registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tc_r <= REG_RESET;
      rc_r <= REG_RESET;
      col_r <= 5'h00;
    end else begin
      tc_r <= tc_nxt;
      rc_r <= rc_nxt;
      col_r <= col_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  store_receive_store_on_a: assert property (rx_store_frame |-> $past(rx_frame_end) && $past(rc_r[RC_RECEIVE_STORE_ON]))
    else $error("frame stored without frame end or with storing off");
  drop_fcs_a: assert property (rx_frame_end && rc_r[RC_DROP_FCS] && rx_fcs_bad |=> !rx_store_frame)
    else $error("bad fcs frame stored");
  drop_long_a: assert property (rx_frame_end && rc_r[RC_DROP_LONG] && rx_frame_len > LEN_LONG
    |=> !rx_store_frame) else $error("oversize frame stored");
  runt_reject_a: assert property (rx_frame_end && !rc_r[RC_RUNT] && rx_frame_len < LEN_MIN
    |=> !rx_store_frame) else $error("short frame stored");
  tx_guard_a: assert property (tx_byte_valid && tx_byte_count >= LEN_GUARD && !tc_r[TC_GUARD_OFF]
    |=> tx_stop_frame) else $error("transmit frame not stopped");
  rx_trunc_a: assert property (rx_byte_valid && rx_byte_count >= LEN_GUARD && !rc_r[RC_GUARD_OFF]
    |=> !rx_store_byte) else $error("received byte stored beyond guard");
  rx_keep_a: assert property (rx_byte_valid && rc_r[RC_RECEIVE_STORE_ON] && (rc_r[RC_GUARD_OFF]
    || rx_byte_count < LEN_GUARD) |=> rx_store_byte) else $error("byte not stored");
  pad_fcs_a: assert property (tx_pad_enable == !tc_r[TC_PAD_OFF] && tx_fcs_enable == !tc_r[TC_FCS_OFF])
    else $error("pad or fcs enable disagrees with control byte");
  abort_many_a: assert property (tx_collision && col_r == COLL_MAX && !tc_r[TC_RETRY] && !tx_frame_start
    |-> ##[1:3] tx_abort_frame) else $error("no abort after too many collisions");
endmodule : mac_ctl_sva
bind mac_status_tx_rx_control mac_ctl_sva i_sva (.*);

/* sim/phy_model.sv */
// receive side of the phy: a byte stream, then frame end with its attributes
`timescale 1ns/1ps
module phy_model
  import mac_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [LEN_W-1:0] len,
  input wire logic [7:0] attr,
  output logic rx_byte_valid,
  output logic [LEN_W-1:0] rx_byte_count,
  output logic rx_frame_end,
  output logic [LEN_W-1:0] rx_frame_len,
  output logic [7:0] fattr
);
  logic busy;
  logic [LEN_W-1:0] cnt, len_q;
  logic [7:0] attr_q;
  // outside their strobe the lines show the inverse, so stale values cannot pass
  assign rx_frame_len = rx_frame_end ? len_q : ~len_q;
  assign fattr = rx_frame_end ? attr_q : ~attr_q;
  assign rx_byte_count = rx_byte_valid ? cnt - 12'h001 : ~cnt;
  // one byte a cycle, then a one cycle frame end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= 12'h000;
      len_q <= 12'h000;
      attr_q <= 8'h00;
      rx_byte_valid <= 1'b0;
      rx_frame_end <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      if (go && !busy) begin
        busy <= 1'b1;
        cnt <= 12'h000;
        len_q <= len;
        attr_q <= attr;
      end else if (busy && cnt < len_q) begin
        rx_byte_valid <= 1'b1;
        cnt <= cnt + 12'h001;
      end else if (busy) begin
        busy <= 1'b0;
        rx_frame_end <= 1'b1;
      end
    end
  end
endmodule : phy_model

/* sim/test_mac_status_tx_rx_control.sv */
// self-checking bench for the mac status and control block
`timescale 1ns/1ps
module test_mac_status_tx_rx_control
  import mac_ctl_pkg::*;
;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, test_strap, phy_link_ok;
  logic phy_speed_10, wakeup_event, rx_frame_end, rx_dest_multicast, rx_dest_match;
  logic rx_hash_match, rx_late_collision, rx_phy_error, rx_odd_bits, rx_fcs_bad;
  logic rx_fifo_overran, rx_byte_valid, tx_byte_valid, tx_collision, tx_frame_start;
  logic rx_store_frame, rx_store_byte, tx_stop_frame, tx_abort_frame, tx_pad_enable;
  logic tx_fcs_enable, outside_phy_select, go;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [3:0] avs_byteenable;
  logic [SPACE_W-1:0] rx_free_space;
  logic [7:0] rx_packet_count, attr, fattr, rd, rc;
  logic [LEN_W-1:0] rx_frame_len, rx_byte_count, tx_byte_count, len;
  logic [LEN_W-1:0] lens [6] = '{12'h03F, 12'h040, 12'h5F2, 12'h5F3, 12'h800, 12'h801};
  logic [7:0] offs [5] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h07};
  int fail_count, cmp_count;
  assign {rx_fifo_overran, rx_fcs_bad, rx_odd_bits, rx_phy_error, rx_late_collision,
          rx_hash_match, rx_dest_match, rx_dest_multicast} = fattr;
  mac_status_tx_rx_control i_dut (.*);
  phy_model i_phy (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic end_of_test(input bit hang);
    if (hang) fail_count++;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one avalon transfer: held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] off, input logic [7:0] wd,
                     input logic [3:0] be);
    int n;
    @(posedge clk);
    avs_address <= {off, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) end_of_test(1);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    bus(1'b1, off, d, 4'hF);
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] off, input logic [7:0] exp);
    bus(1'b0, off, 8'h00, 4'hF);
    check(what, rd, exp);
  endtask : rdc
  // reserved bits 4..2 are masked; the wait covers the input synchronisers
  task automatic nsc(input logic [7:0] exp);
    repeat (8) @(posedge clk);
    bus(1'b0, IDX_NET_STATUS, 8'h00, 4'hF);
    check("net status", rd & 8'hE3, exp);
  endtask : nsc
  // send one frame and compare storing and frame status
  task automatic frame(input logic [LEN_W-1:0] l, input logic [7:0] a);
    int n;
    logic ok;
    len <= l;
    attr <= a;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (rx_frame_end !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) end_of_test(1);
    @(posedge clk);
    ok = rc[RC_RECEIVE_STORE_ON] && !(rc[RC_DROP_FCS] && a[6]) && !(rc[RC_DROP_LONG] && l > LEN_LONG)
      && (l >= LEN_MIN || rc[RC_RUNT]) && (rc[RC_PROMISC] || rc[RC_HASH_FILTER_EVERY_ADDRESS] || a[1] || a[2]
      || (a[0] && rc[RC_ALLMC]));
    if (a[5:3] == 3'b000 && !a[7] && l <= LEN_GUARD)
      check("store", 8'(rx_store_frame), 8'(ok));
    rdc("frame status", IDX_RX_FRAME_STATUS, {l < LEN_MIN, a[0], a[3], l > LEN_GUARD,
        a[4], a[5], a[6], a[7]});
  endtask : frame
  initial begin
    seed = 32'h00002EB4;
    sys_rst = 1'b1;
    {avs_read, avs_write, test_strap, phy_link_ok, phy_speed_10, wakeup_event} = 6'h01 << 3;
    {tx_byte_valid, tx_collision, tx_frame_start, go} = 4'h0;
    {avs_address, avs_writedata, avs_byteenable, rc, attr, len} = '0;
    {rx_free_space, rx_packet_count, tx_byte_count} = {16'hFFFF, 8'h00, 12'h000};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    check("pad fcs", 8'({tx_pad_enable, tx_fcs_enable}), 8'h03);
    for (int i = 0; i < 5; i++) rdc("reset value", offs[i], 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(IDX_TX_CONTROL, seed[7:0]);
      rdc("tx control", IDX_TX_CONTROL, seed[7:0] & TC_WMASK);
      check("pad fcs", 8'({tx_pad_enable, tx_fcs_enable}), 8'({!seed[2], !seed[1]}));
      wr(IDX_RX_CONTROL, seed[15:8]);
      rdc("rx control", IDX_RX_CONTROL, seed[15:8]);
    end
    bus(1'b1, IDX_RX_CONTROL, ~seed[15:8], 4'hE);
    rdc("rx control", IDX_RX_CONTROL, seed[15:8]);
    $display("test control bytes done");
    phy_link_ok <= 1'b1;
    phy_speed_10 <= 1'b1;
    rx_packet_count <= 8'h03;
    rx_free_space <= 16'h021F;
    nsc(8'hC3);
    rx_free_space <= 16'h0800;
    rx_packet_count <= 8'h00;
    nsc(8'hC2);
    rx_free_space <= 16'h0801;
    phy_speed_10 <= 1'b0;
    nsc(8'h40);
    wr(IDX_NET_STATUS, 8'h80);
    nsc(8'h40);
    wr(IDX_FORCE_MODE, 8'h24);
    nsc(8'h80);
    wr(IDX_FORCE_MODE, 8'h00);
    test_strap <= 1'b0;
    repeat (8) @(posedge clk);
    wr(IDX_NET_CONTROL, 8'h80);
    wr(IDX_NET_STATUS, 8'h80);
    nsc(8'h80);
    check("phy select", 8'(outside_phy_select), 8'h01);
    test_strap <= 1'b1;
    nsc(8'h40);
    check("phy select", 8'(outside_phy_select), 8'h00);
    wr(IDX_NET_CONTROL, 8'h40);
    wakeup_event <= 1'b1;
    nsc(8'h60);
    wakeup_event <= 1'b0;
    repeat (8) @(posedge clk);
    wr(IDX_NET_STATUS, 8'h20);
    nsc(8'h40);
    wakeup_event <= 1'b1;
    nsc(8'h60);
    wakeup_event <= 1'b0;
    wr(IDX_NET_CONTROL, 8'h00);
    nsc(8'h40);
    $display("test status done");
    for (int k = 0; k < 4; k++) begin
      wr(IDX_TX_CONTROL, {1'b0, k[1], 6'h00});
      tx_byte_count <= k[0] ? LEN_GUARD : LEN_GUARD - 12'h001;
      tx_byte_valid <= 1'b1;
      @(posedge clk);
      tx_byte_valid <= 1'b0;
      @(posedge clk);
      check("tx stop", 8'(tx_stop_frame), 8'(k == 1));
    end
    for (int k = 0; k < 2; k++) begin
      wr(IDX_TX_CONTROL, {2'b00, k[0], 5'h00});
      tx_frame_start <= 1'b1;
      @(posedge clk);
      tx_frame_start <= 1'b0;
      for (int n = 0; n <= 16; n++) begin
        repeat (3) @(posedge clk);
        check("tx abort", 8'(tx_abort_frame), 8'(k == 0 && n == 16));
        if (n < 16) tx_collision <= 1'b1;
        @(posedge clk);
        tx_collision <= 1'b0;
      end
    end
    $display("test transmit done");
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      rc = {seed[6] & seed[5], seed[14:9], seed[8] | seed[7]};
      wr(IDX_RX_CONTROL, rc);
      frame(i < 6 ? lens[i] : 12'h028 + LEN_W'(seed[10:0]), {seed[31] & seed[30], seed[29],
            seed[28] & seed[27], seed[26] & seed[25], seed[24] & seed[23], seed[22], seed[17:16]});
    end
    $display("test receive done");
    end_of_test(0);
  end
  // hang guard
  initial begin
    #900000;
    end_of_test(1);
  end
endmodule : test_mac_status_tx_rx_control
